/* File: dmpa_map.vh */
// Register map, field positions, reset values and codes of the DMA channel front end
`ifndef DMPA_MAP_VH
`define DMPA_MAP_VH

// Register indices; byte address on APB is four times the index
`define DMPA_IDX_CH0A_MEMORY_ADDRESS  16'hfee0
`define DMPA_IDX_IOA0A  16'hfee4
`define DMPA_IDX_CNT0A  16'hfee6
`define DMPA_IDX_CH0B_MEMORY_ADDRESS  16'hfee8
`define DMPA_IDX_IOA0B  16'hfeec
`define DMPA_IDX_CNT0B  16'hfeee
`define DMPA_IDX_CH1A_MEMORY_ADDRESS  16'hfef0
`define DMPA_IDX_IOA1A  16'hfef4
`define DMPA_IDX_CNT1A  16'hfef6
`define DMPA_IDX_CH1B_MEMORY_ADDRESS  16'hfef8
`define DMPA_IDX_IOA1B  16'hfefc
`define DMPA_IDX_CNT1B  16'hfefe
`define DMPA_IDX_WER    16'hff00
`define DMPA_IDX_TCR    16'hff01
`define DMPA_IDX_CR0A   16'hff02
`define DMPA_IDX_CR0B   16'hff03
`define DMPA_IDX_CR1A   16'hff04
`define DMPA_IDX_CR1B   16'hff05
`define DMPA_IDX_BCR    16'hff06
`define DMPA_IDX_MSTP   16'hff3c

// Reset values
`define DMPA_RST_WER    8'h00
`define DMPA_RST_TCR    8'h00
`define DMPA_RST_CR     8'h00
`define DMPA_RST_BCR    16'h0000
`define DMPA_RST_MSTP   16'h3fff

// Band control fields (index plus channel or sub-channel number)
`define DMPA_BCR_FULL_ADDR_SELECT_CH0   14
`define DMPA_BCR_SAE0   12
`define DMPA_BCR_DTE0   4
`define DMPA_BCR_DTIE0  0

// Sub-channel control fields
`define DMPA_CR_DTSZ    7
`define DMPA_CR_DTID    6
`define DMPA_CR_RPE     5
`define DMPA_CR_DIRECTION_SELECT   4
`define DMPA_DTF_EXT    4'h6

// End pin enable fields and module halt bit
`define DMPA_TCR_TEE0   4
`define DMPA_MSTP_HALT  13

// Fixed upper byte of the I/O side address
`define DMPA_IO_UPPER   8'hff

`endif

/* File: dmpa_iomem.v */
// Small register memory for the fixed I/O addresses, one write and two read ports
`timescale 1ns/1ns
module dmpa_iomem #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_i,
    input  wire             ce_i,
    input  wire             we_i,
    input  wire [AW-1:0]    waddr_i,
    input  wire [WIDTH-1:0] wdata_i,
    input  wire [AW-1:0]    raddr_a_i,
    input  wire [AW-1:0]    raddr_b_i,
    output reg  [WIDTH-1:0] rdata_a_o,
    output reg  [WIDTH-1:0] rdata_b_o
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];

    // No reset: contents survive reset, software must load before use
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_r[waddr_i] <= wdata_i;
            end
            rdata_a_o <= mem_r[raddr_a_i];
            rdata_b_o <= mem_r[raddr_b_i];
        end
    end

endmodule // dmpa_iomem

/* File: dmpa_pin.v */
// Request, acknowledge and transfer end pins of one channel
`timescale 1ns/1ns
module dmpa_pin (
    input  wire clk_i,
    input  wire reset_n_i,
    input  wire ce_i,
    input  wire req_n_i,
    input  wire single_en_i,
    input  wire end_en_i,
    input  wire ack_i,
    input  wire end_i,
    output wire req_fall_o,
    output wire ack_n_o,
    output wire ack_oe_n_o,
    output wire end_n_o,
    output wire end_oe_n_o
);

    reg req_prev_r;
    reg ack_n_r;
    reg end_n_r;

    // Request asks on its falling edge so a held level gives one transfer
    assign req_fall_o = req_prev_r & ~req_n_i;

    // Port line turns to output as soon as single address is chosen
    assign ack_oe_n_o = ~single_en_i;
    assign end_oe_n_o = ~end_en_i;
    assign ack_n_o    = ack_n_r;
    assign end_n_o    = end_n_r;

    // Pin drivers are registered to keep glitches off the board
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_prev_r <= 1'b1;
            ack_n_r    <= 1'b1;
            end_n_r    <= 1'b1;
        end else if (ce_i) begin
            req_prev_r <= req_n_i;
            ack_n_r    <= ~(ack_i & single_en_i);
            end_n_r    <= ~(end_i & end_en_i);
        end
    end

endmodule // dmpa_pin

/* File: dmpa_top.v */
// Two-channel DMA front end: APB registers, address stepping, counting and pins
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "dmpa_map.vh"
module dmpa_top (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        ce_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [17:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire [3:0]  int_request_i,
    input  wire [1:0]  xfer_request_in_n_i,
    output wire [1:0]  xfer_ack_out_n_o,
    output wire [1:0]  xfer_ack_oe_n_o,
    output wire [1:0]  xfer_end_out_n_o,
    output wire [1:0]  xfer_end_oe_n_o,
    output wire        xfer_valid_o,
    output wire [1:0]  xfer_sub_o,
    output wire        xfer_word_o,
    output wire        xfer_single_o,
    output wire [23:0] xfer_src_addr_o,
    output wire [23:0] xfer_dst_addr_o
);

    // Register kinds found by the address decoder
    localparam K_NONE = 3'd0;
    localparam K_MAR  = 3'd1;
    localparam K_IOA  = 3'd2;
    localparam K_CNT  = 3'd3;
    localparam K_CR   = 3'd4;
    localparam K_WER  = 3'd5;
    localparam K_TCR  = 3'd6;
    localparam K_BCR  = 3'd7;

    integer i, i_want, i_step; // Own index per combinational loop; a shared one would wake the other loops

    // Bus side state
    reg        pready_r;
    reg [31:0] prdata_r;
    reg [2:0]  kind;
    reg [1:0]  ksub;
    reg        hit;
    reg        is_mstp;
    reg [31:0] rd_word;
    wire       wr_en;
    wire [15:0] reg_idx;

    // Software visible control
    reg [7:0]  wer_r;
    reg [7:0]  tcr_r;
    reg [15:0] bcr_r;
    reg [15:0] mstp_r;
    reg [7:0]  cr_r [0:3];

    // Address and count registers, deliberately without reset
    reg [23:0] mar_r [0:3];
    reg [15:0] transfer_count_reg_r [0:3];
    reg [23:0] mar_nxt [0:3];

    // Transfer selection
    reg [3:0]  want;
    reg [3:0]  upd;
    reg [3:0]  cnt_last;
    reg [1:0]  ext_used;
    reg [1:0]  ext_pend_r;
    reg [1:0]  gidx;
    reg        ext_ok;
    wire [3:0] gnt;
    wire [1:0] fae;
    wire [1:0] sae;
    wire [1:0] tee;
    wire [3:0] transfer_enable_bit;
    wire [1:0] req_fall;
    wire       halt;
    wire [15:0] io_bus_q;
    wire [15:0] io_eng_q;

    // First pipeline stage: granted transfer
    reg        s1_v_r;
    reg [1:0]  s1_idx_r;
    reg        s1_full_r;
    reg        s1_word_r;
    reg        s1_dir_r;
    reg        s1_single_r;
    reg        s1_end_r;
    reg [23:0] s1_mar_r;
    reg [23:0] s1_marb_r;

    // Second stage: transfer presented to the bus side
    reg        xv_r;
    reg [1:0]  xsub_r;
    reg        xword_r;
    reg        xsingle_r;
    reg [23:0] src_r;
    reg [23:0] dst_r;
    wire [23:0] io_addr;
    wire [1:0] ack_pulse;
    wire [1:0] end_pulse;

    assign reg_idx   = paddr_i[17:2];
    assign wr_en     = psel_i & penable_i & pready_r & pwrite_i;
    assign pready_o  = pready_r;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pready_r & ~hit;

    // Address decode to register kind and sub-channel
    always @* begin
        kind    = K_NONE;
        ksub    = 2'd0;
        hit     = 1'b1;
        is_mstp = 1'b0;
        case (reg_idx)
            `DMPA_IDX_CH0A_MEMORY_ADDRESS: kind = K_MAR;
            `DMPA_IDX_IOA0A: kind = K_IOA;
            `DMPA_IDX_CNT0A: kind = K_CNT;
            `DMPA_IDX_CH0B_MEMORY_ADDRESS: begin kind = K_MAR; ksub = 2'd1; end
            `DMPA_IDX_IOA0B: begin kind = K_IOA; ksub = 2'd1; end
            `DMPA_IDX_CNT0B: begin kind = K_CNT; ksub = 2'd1; end
            `DMPA_IDX_CH1A_MEMORY_ADDRESS: begin kind = K_MAR; ksub = 2'd2; end
            `DMPA_IDX_IOA1A: begin kind = K_IOA; ksub = 2'd2; end
            `DMPA_IDX_CNT1A: begin kind = K_CNT; ksub = 2'd2; end
            `DMPA_IDX_CH1B_MEMORY_ADDRESS: begin kind = K_MAR; ksub = 2'd3; end
            `DMPA_IDX_IOA1B: begin kind = K_IOA; ksub = 2'd3; end
            `DMPA_IDX_CNT1B: begin kind = K_CNT; ksub = 2'd3; end
            `DMPA_IDX_WER:   kind = K_WER;
            `DMPA_IDX_TCR:   kind = K_TCR;
            `DMPA_IDX_CR0A:  kind = K_CR;
            `DMPA_IDX_CR0B:  begin kind = K_CR; ksub = 2'd1; end
            `DMPA_IDX_CR1A:  begin kind = K_CR; ksub = 2'd2; end
            `DMPA_IDX_CR1B:  begin kind = K_CR; ksub = 2'd3; end
            `DMPA_IDX_BCR:   kind = K_BCR;
            `DMPA_IDX_MSTP:  is_mstp = 1'b1;
            default:         hit = 1'b0;
        endcase
    end

    // Read mux; narrow registers sit in the low bits
    always @* begin
        rd_word = 32'h0000_0000;
        case (kind)
            K_MAR:   rd_word = {8'h00, mar_r[ksub]};
            K_IOA:   rd_word = {16'h0000, io_bus_q};
            K_CNT:   rd_word = {16'h0000, transfer_count_reg_r[ksub]};
            K_CR:    rd_word = {24'h00_0000, cr_r[ksub]};
            K_WER:   rd_word = {24'h00_0000, wer_r};
            K_TCR:   rd_word = {24'h00_0000, tcr_r};
            K_BCR:   rd_word = {16'h0000, bcr_r};
            default: rd_word = is_mstp ? {16'h0000, mstp_r} : 32'h0000_0000;
        endcase
    end

    // One wait state gives the I/O memory time to present its word
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_r <= psel_i & penable_i & ~pready_r;
            if (psel_i && penable_i && !pready_r && !pwrite_i) begin
                prdata_r <= rd_word;
            end
        end
    end

    // Control registers; terminal count clears enable unless software writes the same cycle
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wer_r  <= `DMPA_RST_WER;
            tcr_r  <= `DMPA_RST_TCR;
            bcr_r  <= `DMPA_RST_BCR;
            mstp_r <= `DMPA_RST_MSTP;
            for (i = 0; i < 4; i = i + 1) begin
                cr_r[i] <= `DMPA_RST_CR;
            end
        end else if (ce_i) begin
            if (wr_en && kind == K_WER) begin
                wer_r <= pwdata_i[7:0];
            end
            if (wr_en && kind == K_TCR) begin
                tcr_r <= pwdata_i[7:0];
            end
            if (wr_en && is_mstp) begin
                mstp_r <= pwdata_i[15:0];
            end
            if (wr_en && kind == K_CR) begin
                cr_r[ksub] <= pwdata_i[7:0];
            end
            if (wr_en && kind == K_BCR) begin
                bcr_r <= pwdata_i[15:0];
            end else begin
                bcr_r <= bcr_r & ~({12'h000, cnt_last} << `DMPA_BCR_DTE0);
            end
        end
    end

    // Per channel and per sub-channel views of the band control, plus end pin enables and the halt bit
    assign fae  = bcr_r[`DMPA_BCR_FULL_ADDR_SELECT_CH0+1:`DMPA_BCR_FULL_ADDR_SELECT_CH0];
    assign sae  = bcr_r[`DMPA_BCR_SAE0+1:`DMPA_BCR_SAE0];
    assign transfer_enable_bit  = bcr_r[`DMPA_BCR_DTE0+3:`DMPA_BCR_DTE0];
    assign tee  = tcr_r[`DMPA_TCR_TEE0+1:`DMPA_TCR_TEE0];
    assign halt = mstp_r[`DMPA_MSTP_HALT];

    // Which sub-channels ask for a transfer this cycle
    always @* begin
        want   = 4'h0;
        ext_ok = 1'b0;
        for (i_want = 0; i_want < 4; i_want = i_want + 1) begin
            ext_ok = ext_pend_r[i_want/2] & (cr_r[i_want][3:0] == `DMPA_DTF_EXT);
            if (i_want % 2 == 0) begin
                // A ignores the pin in short mode, owns it in full mode
                want[i_want] = transfer_enable_bit[i_want] & (int_request_i[i_want] | (fae[i_want/2] & ext_ok));
            end else if (sae[i_want/2]) begin
                // Single address only runs from the external pin
                want[i_want] = transfer_enable_bit[i_want] & ~fae[i_want/2] & ext_ok;
            end else begin
                want[i_want] = transfer_enable_bit[i_want] & ~fae[i_want/2] & (int_request_i[i_want] | ext_ok);
            end
        end
        if (halt) begin
            want = 4'h0;
        end
    end

    // Fixed priority: 0A, 0B, 1A, 1B
    assign gnt = want & (~want + 4'h1);

    // Address stepping, terminal count and pin consumption
    always @* begin
        upd = gnt | {gnt[2] & fae[1], 1'b0, gnt[0] & fae[0], 1'b0};
        cnt_last = 4'h0;
        ext_used = 2'b00;
        gidx = 2'd0;
        for (i_step = 0; i_step < 4; i_step = i_step + 1) begin
            if (cr_r[i_step][`DMPA_CR_RPE] && bcr_r[`DMPA_BCR_DTIE0 + i_step]) begin
                mar_nxt[i_step] = mar_r[i_step];                // Idle mode holds the address
            end else if (cr_r[i_step][`DMPA_CR_DTID]) begin
                mar_nxt[i_step] = mar_r[i_step] - (cr_r[i_step][`DMPA_CR_DTSZ] ? 24'd2 : 24'd1);
            end else begin
                mar_nxt[i_step] = mar_r[i_step] + (cr_r[i_step][`DMPA_CR_DTSZ] ? 24'd2 : 24'd1);
            end
            cnt_last[i_step] = gnt[i_step] & (transfer_count_reg_r[i_step] == 16'h0001);
            if (gnt[i_step] && cr_r[i_step][3:0] == `DMPA_DTF_EXT) begin
                ext_used[i_step/2] = 1'b1;
            end
            if (gnt[i_step]) begin
                gidx = i_step[1:0];
            end
        end
    end

    // Pending pin request; a new edge beats the clear of the one just used
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_pend_r <= 2'b00;
        end else if (ce_i) begin
            ext_pend_r <= req_fall | (ext_pend_r & ~ext_used);
        end
    end

    // Address and count words; software write wins over a transfer update
    always @(posedge clk_i) begin
        if (ce_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (wr_en && kind == K_MAR && ksub == i[1:0]) begin
                    mar_r[i] <= pwdata_i[23:0];
                end else if (upd[i]) begin
                    mar_r[i] <= mar_nxt[i];
                end
                if (wr_en && kind == K_CNT && ksub == i[1:0]) begin
                    transfer_count_reg_r[i] <= pwdata_i[15:0];
                end else if (gnt[i]) begin
                    transfer_count_reg_r[i] <= transfer_count_reg_r[i] - 16'h0001;
                end
            end
        end
    end

    dmpa_iomem #(
        .WIDTH (16),
        .DEPTH (4),
        .AW    (2)
    ) u_iomem (
        .clk_i     (clk_i),
        .ce_i      (ce_i),
        .we_i      (wr_en && kind == K_IOA),
        .waddr_i   (ksub),
        .wdata_i   (pwdata_i[15:0]),
        .raddr_a_i (ksub),
        .raddr_b_i (gidx),
        .rdata_a_o (io_bus_q),
        .rdata_b_o (io_eng_q)
    );

    // Stage one snapshots the addresses before they step
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_v_r      <= 1'b0;
            s1_idx_r    <= 2'd0;
            s1_full_r   <= 1'b0;
            s1_word_r   <= 1'b0;
            s1_dir_r    <= 1'b0;
            s1_single_r <= 1'b0;
            s1_end_r    <= 1'b0;
            s1_mar_r    <= 24'h00_0000;
            s1_marb_r   <= 24'h00_0000;
        end else if (ce_i) begin
            s1_v_r      <= |gnt;
            s1_idx_r    <= gidx;
            s1_full_r   <= fae[gidx[1]];
            s1_word_r   <= cr_r[gidx][`DMPA_CR_DTSZ];
            s1_dir_r    <= cr_r[gidx][`DMPA_CR_DIRECTION_SELECT];
            s1_single_r <= ~fae[gidx[1]] & sae[gidx[1]] & gidx[0];
            s1_end_r    <= (|cnt_last) & (fae[gidx[1]] | gidx[0]);
            s1_mar_r    <= mar_r[gidx];
            s1_marb_r   <= mar_r[{gidx[1], 1'b1}];
        end
    end

    assign io_addr = {`DMPA_IO_UPPER, io_eng_q};

    // Stage two forms source and destination for the bus side
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xv_r      <= 1'b0;
            xsub_r    <= 2'd0;
            xword_r   <= 1'b0;
            xsingle_r <= 1'b0;
            src_r     <= 24'h00_0000;
            dst_r     <= 24'h00_0000;
        end else if (ce_i) begin
            xv_r      <= s1_v_r;
            xsub_r    <= s1_idx_r;
            xword_r   <= s1_word_r;
            xsingle_r <= s1_single_r;
            if (s1_full_r) begin
                src_r <= s1_mar_r;
                dst_r <= s1_marb_r;
            end else if (s1_dir_r) begin
                src_r <= s1_single_r ? 24'h00_0000 : io_addr;
                dst_r <= s1_mar_r;
            end else begin
                src_r <= s1_mar_r;
                dst_r <= s1_single_r ? 24'h00_0000 : io_addr;
            end
        end
    end

    assign xfer_valid_o    = xv_r;
    assign xfer_sub_o      = xsub_r;
    assign xfer_word_o     = xword_r;
    assign xfer_single_o   = xsingle_r;
    assign xfer_src_addr_o = src_r;
    assign xfer_dst_addr_o = dst_r;

    // One pin block per channel
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_pin
            assign ack_pulse[c] = s1_v_r & s1_single_r & (s1_idx_r[1] == c);
            assign end_pulse[c] = s1_v_r & s1_end_r & (s1_idx_r[1] == c);
            dmpa_pin u_pin (
                .clk_i       (clk_i),
                .reset_n_i   (reset_n_i),
                .ce_i        (ce_i),
                .req_n_i     (xfer_request_in_n_i[c]),
                .single_en_i (~fae[c] & sae[c]),
                .end_en_i    (tee[c]),
                .ack_i       (ack_pulse[c]),
                .end_i       (end_pulse[c]),
                .req_fall_o  (req_fall[c]),
                .ack_n_o     (xfer_ack_out_n_o[c]),
                .ack_oe_n_o  (xfer_ack_oe_n_o[c]),
                .end_n_o     (xfer_end_out_n_o[c]),
                .end_oe_n_o  (xfer_end_oe_n_o[c])
            );
        end
    endgenerate

endmodule // dmpa_top

/* File: dmpa_checker.sv */
// Bus handshake and pin relation checks bound to the DMA front end
`timescale 1ns/1ns
module dmpa_checker (
    input wire       clk_i,
    input wire       reset_n_i,
    input wire       ce_i,
    input wire       psel_i,
    input wire       penable_i,
    input wire       pready_o,
    input wire       pslverr_o,
    input wire [1:0] xfer_ack_out_n_o,
    input wire [1:0] xfer_ack_oe_n_o,
    input wire [1:0] xfer_end_out_n_o,
    input wire [1:0] xfer_end_oe_n_o,
    input wire       xfer_valid_o,
    input wire       xfer_single_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Bus phases; a frozen clock enable stalls the handshake, so both need it
    sequence setup_s; psel_i && !penable_i && ce_i; endsequence
    sequence access_s; psel_i && penable_i && ce_i; endsequence
    acc_answer_a: assert property (setup_s ##1 access_s |=> pready_o)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    ack_pulse_a: assert property (!xfer_ack_out_n_o[0] |=> xfer_ack_out_n_o[0])
        else $error("acknowledge longer than one cycle");
    ack_oe_a: assert property ((~xfer_ack_out_n_o & xfer_ack_oe_n_o) == 2'b00)
        else $error("acknowledge on undriven pin");
    end_oe_a: assert property ((~xfer_end_out_n_o & xfer_end_oe_n_o) == 2'b00)
        else $error("end pulse on disabled pin");
    ack_xfer_a: assert property (xfer_ack_out_n_o != 2'b11 |-> xfer_valid_o && xfer_single_o)
        else $error("acknowledge without single transfer");
    end_xfer_a: assert property (xfer_end_out_n_o != 2'b11 |-> xfer_valid_o)
        else $error("end pulse without transfer");
    reset_pins_a: assert property ($rose(reset_n_i) |-> xfer_ack_oe_n_o == 2'b11 && xfer_end_oe_n_o == 2'b11)
        else $error("pin enables not idle after reset");
endmodule // dmpa_checker

bind dmpa_top dmpa_checker dmpa_checker_i (.clk_i, .reset_n_i, .ce_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
    .xfer_ack_out_n_o, .xfer_ack_oe_n_o, .xfer_end_out_n_o, .xfer_end_oe_n_o, .xfer_valid_o, .xfer_single_o);

/* File: dmpa_periph.sv */
// Behavioural peripheral asking one channel for single address transfers
`timescale 1ns/1ns
module dmpa_periph (
    input  wire logic       clk_i,
    input  wire logic       trig_i,
    input  wire logic [1:0] lag_i,
    input  wire logic       ack_n_i,
    output logic            req_n_o
);
    // Released line sits at its pull-up level; the pin is only ever an input at the device
    // Lag models a slow peripheral; request is held until acknowledged
    initial begin
        req_n_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (trig_i) begin
                repeat (lag_i) @(posedge clk_i);
                req_n_o <= 1'b0;
                @(posedge clk_i iff !ack_n_i);
                req_n_o <= 1'b1;
            end
        end
    end
endmodule // dmpa_periph

/* File: test_dma_channel_pins_and_address_regs.sv */
// Self-checking bench for the DMA front end with a behavioural register model
`timescale 1ns/1ns
module test_dma_channel_pins_and_address_regs;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [17:0] paddr_i = 18'h00000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [3:0]  int_request_i = 4'h0;
    logic        trig = 1'b0;
    logic [1:0]  lag = 2'h0;
    wire  [1:0]  req_n;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, xfer_valid_o, xfer_word_o, xfer_single_o;
    wire  [1:0]  xfer_ack_out_n_o, xfer_ack_oe_n_o, xfer_end_out_n_o, xfer_end_oe_n_o, xfer_sub_o;
    wire  [23:0] xfer_src_addr_o, xfer_dst_addr_o;
    integer      n_errors = 0;
    integer      n_checks = 0;
    integer      i;
    logic [31:0] r, v;
    logic        e;
    logic [23:0] mar_m [4];
    logic [15:0] io_m [4];

    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    dmpa_top dmpa_top_i (.clk_i, .reset_n_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .int_request_i, .xfer_request_in_n_i(req_n), .xfer_ack_out_n_o,
        .xfer_ack_oe_n_o, .xfer_end_out_n_o, .xfer_end_oe_n_o, .xfer_valid_o, .xfer_sub_o, .xfer_word_o,
        .xfer_single_o, .xfer_src_addr_o, .xfer_dst_addr_o);
    dmpa_periph dmpa_periph_i (.clk_i, .trig_i(trig), .lag_i(lag), .ack_n_i(xfer_ack_out_n_o[0]), .req_n_o(req_n[0]));
    assign req_n[1] = 1'b1;

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One APB transfer; waits for pready under a bound, then idles a cycle
    task apb(input logic [15:0] idx, input logic w, input logic [31:0] d);
        integer k;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k == 20) begin n_errors++; tally_and_finish; end
        @(posedge clk_i);
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] d);
        apb(idx, 1'b1, d);
    endtask

    task rd(input logic [15:0] idx, input logic [31:0] ex, input logic ee);
        apb(idx, 1'b0, 32'h00000000);
        chk($sformatf("read %h", idx), ex, r);
        chk($sformatf("pslverr %h", idx), {31'h0, ee}, {31'h0, e});
    endtask

    // Waits for a transfer and compares every field and pin level of it
    task xfer(input logic [23:0] s, input logic [23:0] d, input logic [1:0] sub, input logic sg,
              input logic wd, input logic [1:0] an, input logic [1:0] en);
        integer k;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (xfer_valid_o === 1'b1) break;
        end
        if (k == 40) begin n_errors++; tally_and_finish; end
        chk("src", s, xfer_src_addr_o);
        chk("dst", d, xfer_dst_addr_o);
        chk("sub", sub, xfer_sub_o);
        chk("single", sg, xfer_single_o);
        chk("word", wd, xfer_word_o);
        chk("ack", an, xfer_ack_out_n_o);
        chk("end", en, xfer_end_out_n_o);
    endtask

    initial begin
        void'($urandom(47));
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        // Reset values and an unmapped word
        for (i = 0; i < 7; i++) rd(16'(16'hff00 + i), 32'h0, 1'b0);
        rd(16'hff3c, 32'h3fff, 1'b0);
        rd(16'hff10, 32'h0, 1'b1);
        $display("test reset_values done");
        // Address words: reserved top byte, then contents kept over a reset
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            mar_m[i] = v[23:0];
            io_m[i] = v[31:16] ^ v[15:0];
            wr(16'(16'hfee0 + 8 * i), v);
            rd(16'(16'hfee0 + 8 * i), {8'h00, mar_m[i]}, 1'b0);
            wr(16'(16'hfee4 + 8 * i), {16'h0, io_m[i]});
            rd(16'(16'hfee4 + 8 * i), {16'h0, io_m[i]}, 1'b0);
        end
        reset_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 4; i++) rd(16'(16'hfee0 + 8 * i), {8'h00, mar_m[i]}, 1'b0);
        $display("test address_regs done");
        // Sub-channel 1A by internal request: word, decrement, count of 2
        wr(16'hff3c, 32'h0);
        wr(16'hff01, 32'h30);
        chk("end_oe", 2'b00, xfer_end_oe_n_o);
        wr(16'hff04, 32'hc0);
        wr(16'hfef6, 32'h2);
        wr(16'hff06, 32'h40);
        for (i = 0; i < 2; i++) begin
            int_request_i <= 4'h4;
            @(posedge clk_i);
            int_request_i <= 4'h0;
            xfer(mar_m[2], {8'hff, io_m[2]}, 2'd2, 1'b0, 1'b1, 2'b11, 2'b11);
            mar_m[2] = mar_m[2] - 24'h2;
        end
        rd(16'hfef0, {8'h00, mar_m[2]}, 1'b0);
        rd(16'hfef6, 32'h0, 1'b0);
        rd(16'hff06, 32'h0, 1'b0);
        $display("test internal_xfer done");
        // Sub-channel 0B single address from the pin, direction memory as destination
        wr(16'hff03, 32'h16);
        wr(16'hfeee, 32'h1);
        wr(16'hff06, 32'h1020);
        chk("ack_oe", 2'b10, xfer_ack_oe_n_o);
        lag <= 2'($urandom);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
        xfer(24'h0, mar_m[1], 2'd1, 1'b1, 1'b0, 2'b10, 2'b10);
        rd(16'hfee8, {8'h00, mar_m[1] + 24'h1}, 1'b0);
        rd(16'hff06, 32'h1000, 1'b0);
        $display("test single_xfer done");
        // Channel 0 joined: 0A memory word is source, 0B memory word destination, both step
        mar_m[1] = mar_m[1] + 24'h1;
        wr(16'hff02, 32'h0);
        wr(16'hfee6, 32'h1);
        wr(16'hff06, 32'h4010);
        chk("ack_oe", 2'b11, xfer_ack_oe_n_o);
        int_request_i <= 4'h1;
        @(posedge clk_i);
        int_request_i <= 4'h0;
        xfer(mar_m[0], mar_m[1], 2'd0, 1'b0, 1'b0, 2'b11, 2'b10);
        rd(16'hfee0, {8'h00, mar_m[0] + 24'h1}, 1'b0);
        rd(16'hfee8, {8'h00, mar_m[1] + 24'h1}, 1'b0);
        rd(16'hff06, 32'h4000, 1'b0);
        $display("test full_addr_xfer done");
        tally_and_finish;
    end
endmodule // test_dma_channel_pins_and_address_regs
